// *** sysctl_pkg.sv ***
// constants, types and register map of the system control register bank
package sysctl_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [31:0] IDX_UNLOCK_SIG  = 32'h4000_1040;
    localparam logic [31:0] IDX_PART_CODE   = 32'h4000_1041;
    localparam logic [31:0] IDX_UNLOCK_CON  = 32'h4000_1042;
    localparam logic [31:0] IDX_WDOG_CNT    = 32'h4000_1043;
    localparam logic [31:0] IDX_CAUSE_CFG   = 32'h4000_1044;
    localparam logic [31:0] IDX_CFG_INFO    = 32'h4000_1045;
    localparam logic [31:0] IDX_WDOG_CTRL   = 32'h4000_1046;
    localparam logic [31:0] IDX_KEEP        = 32'h4000_1047;
    localparam logic [31:0] IDX_FW_DATA     = 32'h4000_1800;
    localparam logic [31:0] IDX_FW_CTRL     = 32'h4000_1804;
    localparam logic [31:0] IDX_F_ACC_CTRL  = 32'h4000_1806;
    localparam logic [31:0] IDX_F_ACC_CFG   = 32'h4000_1807;

    // unlock sequence and window
    localparam logic [7:0]  SIG_FIRST       = 8'h57;
    localparam logic [7:0]  SIG_SECOND      = 8'hA8;
    localparam int          UNLOCK_CYCLES   = 16;
    localparam logic [3:0]  UNLOCK_LAST     = 4'(UNLOCK_CYCLES - 1);

    // field positions
    localparam int          SIG_ACT_BIT     = 3;
    localparam int          CFG_CODE_WE_BIT = 7;
    localparam int          CFG_DATA_WE_BIT = 6;
    localparam int          CFG_PORT_EN_BIT = 5;
    localparam int          CFG_OFS_BIT     = 4;
    localparam int          WD_FLAG_BIT     = 4;
    localparam int          WD_INT_EN_BIT   = 2;
    localparam int          WD_RST_EN_BIT   = 1;
    localparam int          WD_SW_RST_BIT   = 0;

    // reset values
    localparam logic [31:0] FW_CTRL_RST     = 32'h0740_0000;
    localparam logic [7:0]  F_ACC_CTRL_RST  = 8'h40;
    localparam logic [7:0]  F_ACC_CFG_RST   = 8'h07;
    localparam logic [7:0]  KEEP_RST        = 8'h00;
    localparam logic [1:0]  CFG_INFO_HI     = 2'b11;

    // watchdog prescale in system clock cycles
    localparam int unsigned WDOG_PRESCALE_CYCLES = 131072;

    // last reset cause codes
    localparam logic [2:0]  CAUSE_SW        = 3'h0;
    localparam logic [2:0]  CAUSE_POR       = 3'h1;
    localparam logic [2:0]  CAUSE_WDOG      = 3'h2;
    localparam logic [2:0]  CAUSE_PIN       = 3'h3;
    localparam logic [2:0]  CAUSE_WAKE_SW   = 3'h4;
    localparam logic [2:0]  CAUSE_SHUTDOWN  = 3'h5;
    localparam logic [2:0]  CAUSE_WAKE_WDOG = 3'h6;
    localparam logic [2:0]  CAUSE_WAKE_PIN  = 3'h7;

    typedef enum logic [1:0] {
        ST_LOCKED = 2'b00,
        ST_FIRST  = 2'b01,
        ST_OPEN   = 2'b11
    } unlock_state_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
    } ahb_req_t;

    typedef struct packed {
        logic code_we;
        logic data_we;
        logic port_en;
        logic ofs_sel;
    } flash_app_cfg_t;

endpackage

// *** system_control_registers.sv ***
// system control register bank behind an ahb-lite slave port
`timescale 1ns/1ps
`default_nettype none

module system_control_registers
    import sysctl_pkg::*;
#(
    parameter logic [7:0]  PART_CODE     = 8'h5A, // arbitrary value
    parameter logic [7:0]  UNLOCK_CONST  = 8'hC3, // arbitrary value
    parameter int unsigned WDOG_PRESCALE = WDOG_PRESCALE_CYCLES
)(
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        manual_reset_i,
    input  wire logic        shutdown_wake_i,
    input  wire logic        local_wake_i,
    input  wire logic [5:0]  cfg_info_i,
    output logic             system_reset_o,
    output logic             watchdog_irq_o,
    output logic             code_area_write_en_o,
    output logic             data_area_write_en_o,
    output logic             flash_port_enable_o,
    output logic             code_start_offset_sel_o,
    output logic             unlock_active_o
);

    localparam int PW = (WDOG_PRESCALE > 1) ? $clog2(WDOG_PRESCALE) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(WDOG_PRESCALE - 1);

    ahb_req_t       req_ff;
    logic [31:0]    hrdata_ff;
    logic           hready_ff;
    unlock_state_t  state_ff;
    unlock_state_t  nxt_state;
    logic [3:0]     timer_ff;
    logic           active_ff;
    logic [PW-1:0]  pre_ff;
    logic [7:0]     wd_cnt_ff;
    logic           wd_flag_ff;
    logic           wd_int_en_ff;
    logic           wd_rst_en_ff;
    logic           irq_ff;
    logic           warm_ff;
    logic [2:0]     cause_ff;
    flash_app_cfg_t cfg_ff;
    logic [7:0]     keep_ff;
    logic [31:0]    fw_data_ff;
    logic [31:0]    fw_ctrl_ff;
    logic [7:0]     f_acc_ctrl_ff;
    logic [7:0]     f_acc_cfg_ff;

    logic           wr_en;
    logic [7:0]     wb;
    logic           wr_sig;
    logic           wr_cnt;
    logic           wr_cfg;
    logic           wr_ctrl;
    logic           prot_ok;
    logic           tick;
    logic           ovf;
    logic           sw_trig;
    logic           wd_trig;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] idx);
        hit = (a == (idx << 2));
    endfunction

    // ahb address phase capture; hsize is ignored, every register is one word
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            req_ff <= '0;
        end
        else if (hready_i)
        begin
            req_ff.valid <= hsel_i & htrans_i[1];
            req_ff.write <= hwrite_i;
            req_ff.addr  <= haddr_i;
        end
    end

    // reads take one wait state so a write just before is already visible
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            hready_ff <= 1'b1;
        else
            hready_ff <= ~(hready_i & hsel_i & htrans_i[1] & ~hwrite_i);
    end

    assign wr_en   = req_ff.valid & req_ff.write & hready_i;
    assign wb      = hwdata_i[7:0];
    assign wr_sig  = wr_en & hit(req_ff.addr, IDX_UNLOCK_SIG);
    assign wr_cnt  = wr_en & hit(req_ff.addr, IDX_WDOG_CNT);
    assign wr_cfg  = wr_en & hit(req_ff.addr, IDX_CAUSE_CFG);
    assign wr_ctrl = wr_en & hit(req_ff.addr, IDX_WDOG_CTRL);
    assign prot_ok = active_ff;

    function automatic logic [31:0] rd_mux(input logic [31:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (hit(a, IDX_UNLOCK_SIG))
            v = {1'b0, timer_ff[3:1], active_ff, 1'b0, state_ff};
        else if (hit(a, IDX_PART_CODE))
            v = PART_CODE;
        else if (hit(a, IDX_UNLOCK_CON))
            v = UNLOCK_CONST;
        else if (hit(a, IDX_WDOG_CNT))
            v = wd_cnt_ff;
        else if (hit(a, IDX_CAUSE_CFG))
            v = {cfg_ff, 1'b0, cause_ff};
        else if (hit(a, IDX_CFG_INFO))
            v = {CFG_INFO_HI, cfg_info_i[5:2], 1'b0, cfg_info_i[0]};
        else if (hit(a, IDX_WDOG_CTRL))
            v = {3'b000, wd_flag_ff, 1'b0, wd_int_en_ff, wd_rst_en_ff, 1'b0};
        else if (hit(a, IDX_KEEP))
            v = keep_ff;
        else if (hit(a, IDX_F_ACC_CTRL))
            v = f_acc_ctrl_ff;
        else if (hit(a, IDX_F_ACC_CFG))
            v = f_acc_cfg_ff;
        rd_mux = {24'h00_0000, v};
        if (hit(a, IDX_FW_DATA))
            rd_mux = fw_data_ff;
        else if (hit(a, IDX_FW_CTRL))
            rd_mux = fw_ctrl_ff;
    endfunction

    // unmapped addresses read zero and ignore writes; response is always okay
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            hrdata_ff <= '0;
        end
        else if (req_ff.valid & ~req_ff.write & ~hready_ff)
        begin
            hrdata_ff <= rd_mux(req_ff.addr);
        end
    end

    // unlock sequence
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_LOCKED:
            begin
                if (wr_sig && wb == SIG_FIRST)
                    nxt_state = ST_FIRST;
            end
            ST_FIRST:
            begin
                if (wr_sig)
                begin
                    if (wb == SIG_SECOND)
                        nxt_state = ST_OPEN;
                    else if (wb == SIG_FIRST)
                        nxt_state = ST_FIRST;
                    else
                        nxt_state = ST_LOCKED;
                end
            end
            ST_OPEN:
            begin
                if (wr_sig)
                    nxt_state = (wb == SIG_FIRST) ? ST_FIRST : ST_LOCKED;
                else if (timer_ff == UNLOCK_LAST)
                    nxt_state = ST_LOCKED;
            end
            default:
            begin
                nxt_state = ST_LOCKED;
            end
        endcase
        if (warm_ff)
            nxt_state = ST_LOCKED;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_ff  <= ST_LOCKED;
            active_ff <= 1'b0;
        end
        else
        begin
            state_ff  <= nxt_state;
            active_ff <= (nxt_state == ST_OPEN);
        end
    end

    // elapsed unlock time, counts only while open
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            timer_ff <= 4'h0;
        else if (nxt_state == ST_OPEN && state_ff == ST_OPEN)
            timer_ff <= timer_ff + 4'h1;
        else
            timer_ff <= 4'h0;
    end

    // watchdog prescaler runs free; a preset does not realign it
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            pre_ff <= '0;
        else if (pre_ff == PRE_LAST)
            pre_ff <= '0;
        else
            pre_ff <= pre_ff + PW'(1);
    end

    assign tick = (pre_ff == PRE_LAST);
    assign ovf  = tick & (wd_cnt_ff == 8'hFF) & ~wr_cnt & ~warm_ff;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            wd_cnt_ff <= 8'h00;
        else if (warm_ff)
            wd_cnt_ff <= 8'h00;
        else if (wr_cnt)
            wd_cnt_ff <= wb;
        else if (tick)
            wd_cnt_ff <= wd_cnt_ff + 8'h01;
    end

    // overflow flag: a set wins over a same-cycle clear through the control register; a count write suppresses the set
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            wd_flag_ff <= 1'b0;
        else if (warm_ff)
            wd_flag_ff <= 1'b0;
        else if (ovf)
            wd_flag_ff <= 1'b1;
        else if (wr_cnt || (wr_ctrl && wb[WD_FLAG_BIT]))
            wd_flag_ff <= 1'b0;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            {wd_int_en_ff, wd_rst_en_ff} <= 2'b00;
        else if (warm_ff)
            {wd_int_en_ff, wd_rst_en_ff} <= 2'b00;
        else if (wr_ctrl && prot_ok)
        begin
            wd_int_en_ff <= wb[WD_INT_EN_BIT];
            wd_rst_en_ff <= wb[WD_RST_EN_BIT];
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            irq_ff <= 1'b0;
        else
            irq_ff <= wd_flag_ff & wd_int_en_ff;
    end

    // system reset request; one cycle wide, then the bank goes to reset values except the scratch byte, start offset select, last cause and watchdog prescaler
    assign sw_trig = wr_ctrl & prot_ok & wb[WD_SW_RST_BIT];
    assign wd_trig = ovf & wd_rst_en_ff;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            warm_ff <= 1'b0;
        else
            warm_ff <= sw_trig | wd_trig | manual_reset_i | shutdown_wake_i | local_wake_i;
    end

    // last reset cause; simultaneous events resolve in the order below
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cause_ff <= CAUSE_POR;
        else if (shutdown_wake_i)
            cause_ff <= CAUSE_SHUTDOWN;
        else if (manual_reset_i)
            cause_ff <= CAUSE_PIN;
        else if (wd_trig)
            cause_ff <= CAUSE_WDOG;
        else if (sw_trig)
        begin
            if (!wd_rst_en_ff)
                cause_ff <= CAUSE_SW;
        end
        else if (local_wake_i)
        begin
            case (cause_ff)
                CAUSE_SW:   cause_ff <= CAUSE_WAKE_SW;
                CAUSE_WDOG: cause_ff <= CAUSE_WAKE_WDOG;
                CAUSE_PIN:  cause_ff <= CAUSE_WAKE_PIN;
                default:    cause_ff <= cause_ff;
            endcase
        end
    end

    // flash application config; one process so the struct has a single driver,
    // and the start offset select ignores warm resets
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cfg_ff <= '0;
        else if (warm_ff)
            {cfg_ff.code_we, cfg_ff.data_we, cfg_ff.port_en} <= 3'b000;
        else if (wr_cfg && prot_ok)
        begin
            cfg_ff.code_we <= wb[CFG_CODE_WE_BIT];
            cfg_ff.data_we <= wb[CFG_DATA_WE_BIT];
            cfg_ff.port_en <= wb[CFG_PORT_EN_BIT];
            cfg_ff.ofs_sel <= wb[CFG_OFS_BIT];
        end
    end

    // scratch byte keeps its value through every warm reset
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            keep_ff <= KEEP_RST;
        else if (wr_en && hit(req_ff.addr, IDX_KEEP))
            keep_ff <= wb;
    end

    // flash engine registers are storage only here
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            {fw_data_ff, fw_ctrl_ff, f_acc_ctrl_ff, f_acc_cfg_ff} <=
                {32'h0000_0000, FW_CTRL_RST, F_ACC_CTRL_RST, F_ACC_CFG_RST};
        else if (warm_ff)
            {fw_data_ff, fw_ctrl_ff, f_acc_ctrl_ff, f_acc_cfg_ff} <=
                {32'h0000_0000, FW_CTRL_RST, F_ACC_CTRL_RST, F_ACC_CFG_RST};
        else if (wr_en)
        begin
            if (hit(req_ff.addr, IDX_FW_DATA))
                fw_data_ff <= hwdata_i;
            if (hit(req_ff.addr, IDX_FW_CTRL))
                fw_ctrl_ff <= hwdata_i;
            if (hit(req_ff.addr, IDX_F_ACC_CTRL))
                f_acc_ctrl_ff <= wb;
            if (hit(req_ff.addr, IDX_F_ACC_CFG))
                f_acc_cfg_ff <= wb;
        end
    end

    assign hrdata_o                = hrdata_ff;
    assign hreadyout_o             = hready_ff;
    assign hresp_o                 = 1'b0;
    assign system_reset_o          = warm_ff;
    assign watchdog_irq_o          = irq_ff;
    assign code_area_write_en_o    = cfg_ff.code_we;
    assign data_area_write_en_o    = cfg_ff.data_we;
    assign flash_port_enable_o     = cfg_ff.port_en;
    assign code_start_offset_sel_o = cfg_ff.ofs_sel;
    assign unlock_active_o         = active_ff;

endmodule

`default_nettype wire

// *** system_control_registers_checker.sv ***
// assertion checker for the system control register bank
`timescale 1ns/1ps
`default_nettype none
module sysctl_checker
    import sysctl_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hready_i,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        manual_reset_i,
    input wire logic        system_reset_o,
    input wire logic        code_area_write_en_o,
    input wire logic        data_area_write_en_o,
    input wire logic        flash_port_enable_o,
    input wire logic        code_start_offset_sel_o,
    input wire logic        unlock_active_o
);
    localparam logic [31:0] SIG_ADDR = IDX_UNLOCK_SIG << 2;
    logic        wph_ff;
    logic [31:0] wad_ff;
    logic [4:0]  open_ff;
    logic        sig_wr;
    logic        sig_a8;
    logic [3:0]  cfg_pins;

    // write data phase tracker; address phase only counts on hready
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wph_ff <= 1'b0;
            wad_ff <= 32'h0000_0000;
        end
        else if (hready_i)
        begin
            wph_ff <= hsel_i & htrans_i[1] & hwrite_i;
            wad_ff <= haddr_i;
        end
    end

    // cycles spent unlocked, cleared whenever locked
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            open_ff <= 5'h00;
        else
            open_ff <= unlock_active_o ? open_ff + 5'h01 : 5'h00;
    end

    assign sig_wr   = wph_ff & hready_i & (wad_ff == SIG_ADDR);
    assign sig_a8   = sig_wr & (hwdata_i[7:0] == SIG_SECOND);
    assign cfg_pins = {code_area_write_en_o, data_area_write_en_o,
                       flash_port_enable_o, code_start_offset_sel_o};

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_rd_wait;
        !hreadyout_o ##1 hreadyout_o;
    endsequence

    a_resp_okay: assert property (hresp_o == 1'b0)
        else $error("slave response not okay");
    a_read_one_wait: assert property (hsel_i && htrans_i[1] && !hwrite_i && hready_i |=> s_rd_wait)
        else $error("read not answered after one wait state");
    a_unlock_source: assert property ($rose(unlock_active_o) |-> $past(sig_a8))
        else $error("unlock without second signature write");
    a_relock_write: assert property (sig_wr && unlock_active_o |=> !unlock_active_o)
        else $error("signature write did not relock");
    a_window_len: assert property ($fell(unlock_active_o) && !$past(sig_wr)
        && !$past(system_reset_o) |-> open_ff == 5'h10)
        else $error("unlock window length wrong");
    a_cfg_needs_open: assert property ($changed(cfg_pins) |-> $past(unlock_active_o)
        || $past(unlock_active_o, 2) || $past(system_reset_o) || $past(system_reset_o, 2))
        else $error("protected config changed while locked");
    a_pin_pulse: assert property (manual_reset_i |=> system_reset_o)
        else $error("pin reset event gave no reset pulse");
    a_pulse_single: assert property (system_reset_o |=> !system_reset_o)
        else $error("reset pulse longer than one cycle");
    a_reset_relocks: assert property (system_reset_o |=> !unlock_active_o)
        else $error("unlock survived a warm reset");
    a_ofs_survives: assert property (system_reset_o |=> $stable(code_start_offset_sel_o))
        else $error("code offset select lost on warm reset");
endmodule

bind system_control_registers sysctl_checker u_chk (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .manual_reset_i(manual_reset_i),
    .system_reset_o(system_reset_o), .code_area_write_en_o(code_area_write_en_o),
    .data_area_write_en_o(data_area_write_en_o), .flash_port_enable_o(flash_port_enable_o),
    .code_start_offset_sel_o(code_start_offset_sel_o), .unlock_active_o(unlock_active_o)
);
`default_nettype wire

// *** tb_system_control_registers.sv ***
// self-checking testbench for the system control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_system_control_registers
    import sysctl_pkg::*;
;
    localparam int          PRE = 16;    // short prescale keeps the run brief
    localparam logic [7:0]  PC  = 8'h5A; // arbitrary value
    localparam logic [7:0]  UC  = 8'hC3; // arbitrary value
    localparam logic [31:0] A_SIG = IDX_UNLOCK_SIG << 2, A_PC = IDX_PART_CODE << 2,
        A_UC = IDX_UNLOCK_CON << 2, A_WD = IDX_WDOG_CNT << 2, A_CF = IDX_CAUSE_CFG << 2,
        A_IN = IDX_CFG_INFO << 2, A_CT = IDX_WDOG_CTRL << 2, A_KP = IDX_KEEP << 2,
        A_FD = IDX_FW_DATA << 2, A_FC = IDX_FW_CTRL << 2, A_FA = IDX_F_ACC_CTRL << 2,
        A_FG = IDX_F_ACC_CFG << 2, A_NO = 32'h0000_4120;
    logic        clock_i         = 1'b0;
    logic        sys_rst_i       = 1'b1;
    logic        hsel_i          = 1'b0;
    logic        hwrite_i        = 1'b0;
    logic [1:0]  htrans_i        = 2'b00;
    logic [31:0] haddr_i         = 32'h0000_0000;
    logic [31:0] hwdata_i        = 32'h0000_0000;
    logic        manual_reset_i  = 1'b0;
    logic        shutdown_wake_i = 1'b0;
    logic        local_wake_i    = 1'b0;
    logic [31:0] hrdata_o;
    logic        hreadyout_o, hresp_o, system_reset_o, watchdog_irq_o, unlock_active_o;
    logic [3:0]  pins;
    int          err_count = 0, total_checks = 0, seed = 82, n, i;
    logic [31:0] q, v;
    time         t_prev, t_last;
    logic        irq_q = 1'b0;
    int          ek [7] = '{0, 2, 1, 3, 2, 4, 2};
    logic [2:0]  ec [7] = '{3'h3, 3'h7, 3'h5, 3'h0, 3'h4, 3'h2, 3'h6};
    logic [31:0] ra [12] = '{A_SIG, A_PC, A_UC, A_WD, A_CF, A_IN, A_CT, A_KP, A_FC, A_FA,
        A_FG, A_NO};
    logic [31:0] re [12] = '{32'h0000_0000, {24'h00_0000, PC}, {24'h00_0000, UC},
        32'h0000_0000, 32'h0000_0001, {24'h00_0000, CFG_INFO_HI, 6'h2D}, 32'h0000_0000,
        {24'h00_0000, KEEP_RST}, FW_CTRL_RST, {24'h00_0000, F_ACC_CTRL_RST},
        {24'h00_0000, F_ACC_CFG_RST}, 32'h0000_0000};

    system_control_registers #(.PART_CODE(PC), .UNLOCK_CONST(UC), .WDOG_PRESCALE(PRE)) uut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .manual_reset_i(manual_reset_i),
        .shutdown_wake_i(shutdown_wake_i), .local_wake_i(local_wake_i),
        .cfg_info_i(6'h2D), .system_reset_o(system_reset_o),
        .watchdog_irq_o(watchdog_irq_o), .code_area_write_en_o(pins[3]),
        .data_area_write_en_o(pins[2]), .flash_port_enable_o(pins[1]),
        .code_start_offset_sel_o(pins[0]), .unlock_active_o(unlock_active_o));

    always #10 clock_i = ~clock_i;

    // times of irq rising edges, for the prescale period
    always @(negedge clock_i)
    begin
        if (watchdog_irq_o === 1'b1 && irq_q !== 1'b1)
        begin
            t_prev = t_last;
            t_last = $time;
        end
        irq_q = watchdog_irq_o;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // expected signature read: elapsed-time field left at zero
    function automatic logic [31:0] sig_exp(input logic act, input logic [1:0] st);
        sig_exp = {28'h000_0000, act, 1'b0, st};
    endfunction

    // hready is looked at on the falling edge, so it equals what the next rising edge samples
    task automatic hold;
        logic r;
        int   k;
        k = 0;
        do
        begin
            @(negedge clock_i);
            r = hreadyout_o;
            q = hrdata_o;
            @(posedge clock_i);
            k++;
        end
        while (r !== 1'b1 && k < 64);
        if (r !== 1'b1)
        begin
            err_count++;
            $display("unexpected bus hang at %h", haddr_i);
            test_done;
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel_i   <= 1'b1;
        haddr_i  <= a;
        hwrite_i <= w;
        htrans_i <= 2'b10;
        hold;
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        hold;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, q, exp);
    endtask

    task automatic unlock;
        wr(A_SIG, {24'h00_0000, SIG_FIRST});
        wr(A_SIG, {24'h00_0000, SIG_SECOND});
    endtask

    // k: 0 unlock gone, 1 irq up, 2 reset pulse; n counts falling edges
    task automatic wait_for(input int k);
        logic s;
        n = 0;
        do
        begin
            @(negedge clock_i);
            n++;
            s = k == 0 ? !unlock_active_o : k == 1 ? watchdog_irq_o : system_reset_o;
        end
        while (s !== 1'b1 && n < 4 * PRE + 40);
        if (s !== 1'b1)
        begin
            err_count++;
            $display("unexpected wait %0d timed out", k);
            test_done;
        end
        @(posedge clock_i);
    endtask

    task automatic event_run(input int k);
        case (k)
            0: manual_reset_i <= 1'b1;
            1: shutdown_wake_i <= 1'b1;
            2: local_wake_i <= 1'b1;
            3:
            begin
                unlock;
                wr(A_CT, 32'h0000_0001);
            end
            default:
            begin
                unlock;
                wr(A_CT, 32'h0000_0002);
                wr(A_WD, 32'h0000_00FF);
            end
        endcase
        if (k < 3)
        begin
            @(posedge clock_i);
            {manual_reset_i, shutdown_wake_i, local_wake_i} <= 3'b000;
        end
        wait_for(2);
    endtask

    initial
    begin
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        for (i = 0; i < 12; i++)
            rdc("reset value", ra[i], re[i]);
        v = $random(seed);
        wr(A_PC, v);
        wr(A_UC, v);
        wr(A_NO, v);
        rdc("part code", A_PC, {24'h00_0000, PC});
        rdc("unlock const", A_UC, {24'h00_0000, UC});
        rdc("unmapped", A_NO, 32'h0000_0000);
        $display("test done: reset values and read-only places");
        wr(A_CF, 32'h0000_00F0);
        rdc("locked cfg", A_CF, 32'h0000_0001);
        wr(A_SIG, 32'h0000_0057);
        wr(A_SIG, 32'h0000_0011);
        wr(A_SIG, 32'h0000_00A8);
        @(negedge clock_i);
        chk("broken sequence", 32'(unlock_active_o), 32'h0000_0000);
        @(posedge clock_i);
        unlock;
        wait_for(0);
        chk("window", 32'(n), 32'(UNLOCK_CYCLES + 1));
        wr(A_SIG, 32'h0000_0057);
        rdc("armed sig", A_SIG, sig_exp(1'b0, 2'b01));
        wr(A_SIG, 32'h0000_00A8);
        bus(1'b0, A_SIG, 32'h0000_0000);
        chk("open sig", q & 32'hFFFF_FF8F, sig_exp(1'b1, 2'b11));
        wr(A_CF, 32'h0000_00F0);
        @(negedge clock_i);
        chk("cfg pins", 32'(pins), 32'h0000_000F);
        @(posedge clock_i);
        rdc("open cfg", A_CF, 32'h0000_00F1);
        unlock;
        wr(A_SIG, 32'h0000_0000);
        @(negedge clock_i);
        chk("relock", 32'(unlock_active_o), 32'h0000_0000);
        @(posedge clock_i);
        wr(A_CF, 32'h0000_0000);
        rdc("relocked cfg", A_CF, 32'h0000_00F1);
        $display("test done: unlock sequence and window");
        unlock;
        wr(A_CT, 32'h0000_0004);
        wr(A_WD, 32'h0000_00FF);
        wait_for(1);
        wr(A_WD, 32'h0000_00FF);
        repeat (2) @(posedge clock_i);
        wait_for(1);
        chk("wdog period", 32'(t_last - t_prev), 32'(PRE * 20));
        rdc("wrapped count", A_WD, 32'h0000_0000);
        rdc("flag set", A_CT, 32'h0000_0014);
        wr(A_CT, 32'h0000_0010);
        rdc("flag cleared", A_CT, 32'h0000_0004);
        for (i = 0; i < 4; i++)
        begin
            v = $random(seed);
            wr(A_FD, v);
            rdc("flash data", A_FD, v);
        end
        $display("test done: watchdog and storage");
        v = $random(seed);
        wr(A_KP, {24'h00_0000, v[7:0]});
        for (i = 0; i < 7; i++)
        begin
            event_run(ek[i]);
            rdc("cause", A_CF, {24'h00_0000, 4'h1, 1'b0, ec[i]});
            rdc("ctrl after reset", A_CT, 32'h0000_0000);
        end
        rdc("scratch kept", A_KP, {24'h00_0000, v[7:0]});
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rdc("power-on cause", A_CF, 32'h0000_0001);
        rdc("power-on scratch", A_KP, 32'h0000_0000);
        $display("test done: reset causes");
        test_done;
    end
endmodule
`default_nettype wire
